// file: bench/tcr_host_model.sv
// Behavioural host that writes and reads the register bank over the four-wire link.
`timescale 1ns/1ps
module tcr_host_model #(
    parameter logic [2:0] CHIP = 3'h0
) (
    input wire logic i_ref_clk,
    input wire logic i_serial_out,
    output logic o_serial_clk,
    output logic o_serial_select_n,
    output logic o_serial_in
);
    logic s [0:47];
    // The link clock stands low and select high between frames.
    initial begin
        o_serial_clk = 1'b0;
        o_serial_select_n = 1'b1;
        o_serial_in = 1'b0;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge i_ref_clk);
    endtask
    // Sends n clocks of a frame, msb first; data moves only while the clock is low.
    task automatic send(input logic [4:0] num, input logic [15:0] d, input int n = 24,
        input logic [2:0] chip = CHIP);
        logic [23:0] f;
        f = {chip, num, d};
        tick(1);
        o_serial_select_n <= 1'b0;
        for (int i = 0; i < n; i++) begin
            o_serial_in <= f[23 - i];
            tick(4);
            o_serial_clk <= 1'b1;
            tick(4);
            o_serial_clk <= 1'b0;
        end
        tick(2);
        o_serial_select_n <= 1'b1;
        o_serial_in <= ~o_serial_in; // A released line no longer shows the last bit.
        tick(12);
    endtask
    // Arms a read and gives 48 clocks, sampling late in each high phase when the bit is settled.
    task automatic read(input logic [4:0] target, output logic [15:0] val, output logic tail);
        send(tcr_pkg::REG_READ_SELECT, {target, 11'h000});
        o_serial_select_n <= 1'b0;
        for (int i = 0; i < 48; i++) begin
            o_serial_clk <= 1'b1;
            tick(3);
            s[i] = i_serial_out;
            tick(1);
            o_serial_clk <= 1'b0;
            tick(4);
        end
        tick(2);
        o_serial_select_n <= 1'b1;
        tick(12);
        tail = 1'b0;
        for (int i = 0; i < 48; i++) begin
            if (i > 0 && i < 17) val[16 - i] = s[i];
            else tail = tail | s[i];
        end
    endtask
endmodule // tcr_host_model

// file: bench/tcr_regs_monitor.sv
// Checker that ties the register bank outputs to the serial link inputs.
`timescale 1ns/1ps
module tcr_regs_checker (
    input wire logic i_ref_clk,
    input wire logic i_srst,
    input wire logic i_serial_clk,
    input wire logic i_serial_select_n,
    input wire logic o_serial_out,
    input wire logic o_square_detector_on,
    input wire logic o_envelope_detector_on,
    input wire logic o_vga_on,
    input wire logic o_image_mixer_on,
    input wire logic o_mixer_quad_lines_on,
    input wire logic o_stepped_amp_on,
    input wire logic o_lowpass_stage_on,
    input wire logic [15:0] o_stage_enables,
    input wire logic [1:0] o_amplifier_current,
    input wire logic [4:0] o_envelope_level,
    input wire logic [1:0] o_attenuation_bias
);
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (i_srst);
    logic [5:0] since_sel;
    logic [5:0] since_fall;
    logic clk_q;
    // Ages since select was last low and since the link clock last fell, saturating.
    always_ff @(posedge i_ref_clk) begin
        clk_q <= i_serial_clk;
        since_sel <= (i_srst || since_sel == 6'h3F) ? 6'h3F : since_sel + 6'h01;
        since_fall <= (i_srst || since_fall == 6'h3F) ? 6'h3F : since_fall + 6'h01;
        if (!i_serial_select_n) since_sel <= 6'h00;
        if (clk_q && !i_serial_clk) since_fall <= 6'h00;
    end
    // Steps that mark the first edge after reset has been released.
    sequence s_held;
        $past(i_srst);
    endsequence
    sequence s_release;
        s_held ##0 !i_srst;
    endsequence
    a_square_bit: assert property (o_square_detector_on == o_stage_enables[6])
        else $error("square detector output differs from its enable bit");
    a_envelope_inverse: assert property (o_envelope_detector_on == !o_stage_enables[5])
        else $error("envelope detector output not inverse of its bit");
    a_vga_bit: assert property (o_vga_on == o_stage_enables[4])
        else $error("gain amplifier output differs from its enable bit");
    a_mixer_bit: assert property (o_image_mixer_on == o_stage_enables[3])
        else $error("image mixer output differs from its enable bit");
    a_quad_lines_bit: assert property (o_mixer_quad_lines_on == o_stage_enables[2])
        else $error("quadrature lines output differs from its enable bit");
    a_stepped_bit: assert property (o_stepped_amp_on == o_stage_enables[1])
        else $error("stepped amplifier output differs from its enable bit");
    a_lowpass_bit: assert property (o_lowpass_stage_on == o_stage_enables[0])
        else $error("lowpass output differs from its enable bit");
    a_reset_values: assert property (s_release |-> o_stage_enables[6:0] == 7'h7A
        && o_amplifier_current == 2'h3 && o_envelope_level == 5'h1C && o_attenuation_bias == 2'h2)
        else $error("reset values wrong after release");
    a_load_after_frame: assert property (!$past(i_srst, 2) && $changed({o_stage_enables,
        o_amplifier_current, o_envelope_level, o_attenuation_bias}) |-> since_sel < 6'd12)
        else $error("register output changed without a closing frame");
    a_sout_after_fall: assert property ($changed(o_serial_out) |-> since_fall < 6'd8)
        else $error("readback bit changed away from a link falling edge");
    a_sout_idle_low: assert property (since_sel == 6'h3F |-> !o_serial_out)
        else $error("readback line high outside a read");
endmodule // tcr_regs_checker
bind tcr_regs tcr_regs_checker u_chk (.i_ref_clk, .i_srst, .i_serial_clk, .i_serial_select_n,
    .o_serial_out, .o_square_detector_on, .o_envelope_detector_on, .o_vga_on, .o_image_mixer_on,
    .o_mixer_quad_lines_on, .o_stepped_amp_on, .o_lowpass_stage_on, .o_stage_enables,
    .o_amplifier_current, .o_envelope_level, .o_attenuation_bias);

// file: bench/test_tcr_regs.sv
// Self-checking testbench of the control register bank driven by the host model.
`timescale 1ns/1ps
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin fail_count++; \
    $display("wrong value %s expected %h seen %h", n, e, g); end end
module test_tcr_regs;
    localparam logic [2:0] CHIP = 3'h5;
    logic i_ref_clk = 1'b0;
    logic i_srst = 1'b1;
    logic sclk, ssel_n, sdin, sout, sq, env, vga, mix, quad, step, lp, sb, ipol, qpol, tail;
    logic [15:0] stage, rd;
    logic [5:0] gain;
    logic [1:0] cur, att;
    logic [4:0] lvl;
    logic [7:0] imag, qmag;
    logic [8:0] itrim, qtrim;
    int fail_count = 0;
    int compares = 0;
    // Free-running 100 MHz clock.
    always #5 i_ref_clk = ~i_ref_clk;
    tcr_regs #(.CHIP_ADDR(CHIP)) DUT (.i_ref_clk(i_ref_clk), .i_srst(i_srst),
        .i_serial_clk(sclk), .i_serial_select_n(ssel_n), .i_serial_in(sdin), .o_serial_out(sout),
        .o_square_detector_on(sq), .o_envelope_detector_on(env), .o_vga_on(vga),
        .o_image_mixer_on(mix), .o_mixer_quad_lines_on(quad), .o_stepped_amp_on(step),
        .o_lowpass_stage_on(lp), .o_stage_enables(stage), .o_gain_step_code(gain),
        .o_amplifier_current(cur), .o_envelope_level(lvl), .o_attenuation_bias(att),
        .o_sideband_select(sb), .o_inphase_offset_pol(ipol), .o_inphase_offset_mag(imag),
        .o_quad_offset_pol(qpol), .o_quad_offset_mag(qmag), .o_inphase_phase_trim_val(itrim),
        .o_quad_phase_trim_val(qtrim));
    tcr_host_model #(.CHIP(CHIP)) host (.i_ref_clk(i_ref_clk), .i_serial_out(sout),
        .o_serial_clk(sclk), .o_serial_select_n(ssel_n), .o_serial_in(sdin));
    // Reset values at the outputs and through readback.
    task automatic t_reset();
        `CHK("enable bits", 7'h7A, stage[6:0])
        `CHK("stage word", 16'hD9FA, stage)
        `CHK("stage outputs", 7'b1011010, {sq, env, vga, mix, quad, step, lp})
        `CHK("gain", 6'h00, gain)
        `CHK("bias", 9'b11_11100_10, {cur, lvl, att})
        `CHK("sideband", 10'h200, {sb, ipol, imag})
        `CHK("trims", 36'h0, {qpol, qmag, itrim, qtrim})
        host.read(tcr_pkg::REG_MIX_Q_OFFSET, rd, tail);
        `CHK("q offset readback", 17'h0F000, {tail, rd})
        host.read(tcr_pkg::REG_INPHASE_TRIM, rd, tail);
        `CHK("phase readback", 17'h0F000, {tail, rd})
    endtask
    // Each stage enable alone, with the upper bits kept at their pattern.
    task automatic t_enables();
        for (int b = 0; b < 7; b++) begin
            host.send(tcr_pkg::REG_STAGE_ENABLES, 16'hD980 | (16'h0001 << b));
            `CHK("enable bits", 7'h01 << b, stage[6:0])
            `CHK("stage word", 16'hD980 | (16'h0001 << b), stage)
            `CHK("stage outputs", (7'h01 << b) ^ 7'h20, {sq, env, vga, mix, quad, step, lp})
        end
    endtask
    // Gain codes at both ends of the range.
    task automatic t_gain();
        logic [5:0] codes [0:2];
        codes = '{6'h23, 6'h01, 6'h00};
        for (int i = 0; i < 3; i++) begin
            host.send(tcr_pkg::REG_GAIN_STEP, {1'b0, codes[i], 9'h000});
            `CHK("gain", codes[i], gain)
        end
        host.send(tcr_pkg::REG_AMP_BIAS, {7'b0000111, 2'b01, 5'b10101, 2'b01});
        `CHK("bias", 9'b01_10101_01, {cur, lvl, att})
    endtask
    // Both sidebands, offsets and phase trims, then a readback of the last write.
    task automatic t_mixer();
        for (int i = 0; i < 2; i++) begin
            host.send(tcr_pkg::REG_MIX_SIDEBAND_I, {4'b0010, i[0], 2'b01, 1'b1, 8'hC3});
            `CHK("sideband", {i[0], 9'h1C3}, {sb, ipol, imag})
        end
        host.send(tcr_pkg::REG_MIX_Q_OFFSET, {7'b1111000, 1'b1, 8'h5A});
        host.send(tcr_pkg::REG_INPHASE_TRIM, {7'b1111000, 9'h1C3});
        host.send(tcr_pkg::REG_QUAD_TRIM, {7'b1111000, 9'h0AB});
        `CHK("trims", {9'h15A, 9'h1C3, 9'h0AB}, {qpol, qmag, itrim, qtrim})
        host.read(tcr_pkg::REG_QUAD_TRIM, rd, tail);
        `CHK("q phase readback", {1'b0, 7'b1111000, 9'h0AB}, {tail, rd})
    endtask
    // Frames for another chip or one clock short change nothing.
    task automatic t_refuse();
        host.send(tcr_pkg::REG_STAGE_ENABLES, 16'hD9FF, 24, CHIP ^ 3'h1);
        `CHK("foreign chip", 7'h40, stage[6:0])
        host.send(tcr_pkg::REG_STAGE_ENABLES, 16'hD9FF, 23);
        `CHK("short frame", 7'h40, stage[6:0])
        host.read(5'h1F, rd, tail);
        `CHK("unmapped readback", 17'h0, {tail, rd})
    endtask
    // Prints the counts and the verdict, then ends the run.
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // Reset for 8 cycles, then every scenario in turn.
    initial begin
        repeat (8) @(posedge i_ref_clk);
        i_srst <= 1'b0;
        repeat (3) @(posedge i_ref_clk);
        t_reset();
        t_enables();
        t_gain();
        t_mixer();
        t_refuse();
        conclude();
    end
endmodule // test_tcr_regs

// file: hdl/tcr_link_sync.sv
// Two-flop synchronisers for the serial pins plus link clock edge detection.
`timescale 1ns/1ps
module tcr_link_sync (
    input wire logic i_ref_clk,
    input wire logic i_srst,
    input wire logic i_clk,
    input wire logic i_sel_n,
    input wire logic i_din,
    tcr_sync_if.src sync
);
    logic [1:0] clk_s;
    logic [1:0] sel_s;
    logic [1:0] din_s;
    logic clk_d;

    // Each pin passes two flops; clk_d holds the previous synced clock.
    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            clk_s <= 2'h0;
            sel_s <= 2'h3;
            din_s <= 2'h0;
            clk_d <= 1'b0;
        end else begin
            clk_s <= {clk_s[0], i_clk};
            sel_s <= {sel_s[0], i_sel_n};
            din_s <= {din_s[0], i_din};
            clk_d <= clk_s[1];
        end
    end

    // Edge events look only at the second stage.
    assign sync.rise = clk_s[1] & ~clk_d;
    assign sync.fall = ~clk_s[1] & clk_d;
    assign sync.select_n = sel_s[1];
    assign sync.data_in = din_s[1];
endmodule // tcr_link_sync

// file: hdl/tcr_pkg.sv
// Package with register numbers, field positions, reset values and frame counts.
package tcr_pkg;
    localparam logic [4:0] REG_STAGE_ENABLES = 5'h01;
    localparam logic [4:0] REG_GAIN_STEP = 5'h03;
    localparam logic [4:0] REG_AMP_BIAS = 5'h04;
    localparam logic [4:0] REG_MIX_SIDEBAND_I = 5'h05;
    localparam logic [4:0] REG_MIX_Q_OFFSET = 5'h06;
    localparam logic [4:0] REG_READ_SELECT = 5'h07;
    localparam logic [4:0] REG_INPHASE_TRIM = 5'h08;
    localparam logic [4:0] REG_QUAD_TRIM = 5'h09;
    // Reset values of each 16-bit register except the read select register.
    localparam logic [15:0] RST_STAGE_ENABLES = 16'hD9FA;
    localparam logic [15:0] RST_GAIN_STEP = 16'h0000;
    localparam logic [15:0] RST_AMP_BIAS = 16'h0FF2;
    localparam logic [15:0] RST_MIX_SIDEBAND_I = 16'h2A00;
    localparam logic [15:0] RST_MIX_Q_OFFSET = 16'hF000;
    localparam logic [15:0] RST_INPHASE_TRIM = 16'hF000;
    localparam logic [15:0] RST_QUAD_TRIM = 16'hF000;
    // Field positions.
    localparam int BIT_SQUARE_DET = 6;
    localparam int BIT_ENVELOPE_OFF = 5;
    localparam int BIT_VGA_ON = 4;
    localparam int BIT_IMAGE_MIXER = 3;
    localparam int BIT_QUAD_LINES = 2;
    localparam int BIT_STEPPED_AMP = 1;
    localparam int BIT_LOWPASS = 0;
    localparam int GAIN_HI = 14;
    localparam int GAIN_LO = 9;
    localparam logic [5:0] GAIN_MAX = 6'h23;
    localparam int SIDEBAND_BIT = 11;
    localparam int POLARITY_BIT = 8;
    // Frame lengths in link clocks.
    localparam logic [5:0] FRAME_BITS = 6'h18;
    localparam logic [5:0] READ_CLOCKS = 6'h30;
    localparam int ADDR_BITS = 3;
    localparam logic [2:0] CHIP_ADDR_DEFAULT = 3'h0;
endpackage

// file: hdl/tcr_regs.sv
// Serially written control register bank of the transmitter chain.
`timescale 1ns/1ps
module tcr_regs #(
    parameter logic [2:0] CHIP_ADDR = tcr_pkg::CHIP_ADDR_DEFAULT
) (
    input wire logic i_ref_clk,
    input wire logic i_srst,
    input wire logic i_serial_clk,
    input wire logic i_serial_select_n,
    input wire logic i_serial_in,
    output logic o_serial_out,
    output logic o_square_detector_on,
    output logic o_envelope_detector_on,
    output logic o_vga_on,
    output logic o_image_mixer_on,
    output logic o_mixer_quad_lines_on,
    output logic o_stepped_amp_on,
    output logic o_lowpass_stage_on,
    output logic [15:0] o_stage_enables,
    output logic [5:0] o_gain_step_code,
    output logic [1:0] o_amplifier_current,
    output logic [4:0] o_envelope_level,
    output logic [1:0] o_attenuation_bias,
    output logic o_sideband_select,
    output logic o_inphase_offset_pol,
    output logic [7:0] o_inphase_offset_mag,
    output logic o_quad_offset_pol,
    output logic [7:0] o_quad_offset_mag,
    output logic [8:0] o_inphase_phase_trim_val,
    output logic [8:0] o_quad_phase_trim_val
);
    typedef enum logic [1:0] {
        TCR_IDLE = 2'b00,
        TCR_SHIFT = 2'b01,
        TCR_READ = 2'b10
    } tcr_state_t;

    tcr_sync_if sync ();

    tcr_link_sync u_sync (
        .i_ref_clk(i_ref_clk),
        .i_srst(i_srst),
        .i_clk(i_serial_clk),
        .i_sel_n(i_serial_select_n),
        .i_din(i_serial_in),
        .sync(sync)
    );

    tcr_state_t state;
    tcr_state_t next_state;
    logic [23:0] shift;
    logic [5:0] count;
    logic [4:0] read_sel;
    logic [15:0] read_shift;
    logic [15:0] stage_enables;
    logic [15:0] gain_step_control;
    logic [15:0] amp_bias_settings;
    logic [15:0] mixer_sideband_i_offset;
    logic [15:0] mixer_q_offset;
    logic [15:0] inphase_phase_trim;
    logic [15:0] quadrature_phase_trim;
    logic [15:0] read_select_reg;

    // Frame fields and the load decision taken as select returns high.
    wire select_rise;
    wire frame_done;
    wire addr_match;
    wire [4:0] frame_reg;
    wire [15:0] frame_data;
    wire do_load;
    wire read_armed;
    assign select_rise = (state != TCR_IDLE) && sync.select_n;
    assign frame_done = (count == tcr_pkg::FRAME_BITS);
    assign frame_reg = shift[20:16];
    assign frame_data = shift[15:0];
    assign addr_match = (shift[23:21] == CHIP_ADDR);
    assign do_load = (state == TCR_SHIFT) && select_rise && frame_done && addr_match;
    assign read_armed = do_load && (frame_reg == tcr_pkg::REG_READ_SELECT);

    // One load strobe per mapped register; frame_reg makes at most one of them high.
    // Unmapped register numbers raise none of them, so such a frame is dropped.
    wire load_stage = do_load && (frame_reg == tcr_pkg::REG_STAGE_ENABLES);
    wire load_gain = do_load && (frame_reg == tcr_pkg::REG_GAIN_STEP);
    wire load_bias = do_load && (frame_reg == tcr_pkg::REG_AMP_BIAS);
    wire load_sideband = do_load && (frame_reg == tcr_pkg::REG_MIX_SIDEBAND_I);
    wire load_q_offset = do_load && (frame_reg == tcr_pkg::REG_MIX_Q_OFFSET);
    wire load_read_select = do_load && (frame_reg == tcr_pkg::REG_READ_SELECT);
    wire load_itrim = do_load && (frame_reg == tcr_pkg::REG_INPHASE_TRIM);
    wire load_qtrim = do_load && (frame_reg == tcr_pkg::REG_QUAD_TRIM);

    // Selected register for readback; unmapped numbers read as zero.
    logic [15:0] read_word;
    always_comb begin
        unique case (read_sel)
            tcr_pkg::REG_STAGE_ENABLES: read_word = stage_enables;
            tcr_pkg::REG_GAIN_STEP: read_word = gain_step_control;
            tcr_pkg::REG_AMP_BIAS: read_word = amp_bias_settings;
            tcr_pkg::REG_MIX_SIDEBAND_I: read_word = mixer_sideband_i_offset;
            tcr_pkg::REG_MIX_Q_OFFSET: read_word = mixer_q_offset;
            tcr_pkg::REG_READ_SELECT: read_word = read_select_reg;
            tcr_pkg::REG_INPHASE_TRIM: read_word = inphase_phase_trim;
            tcr_pkg::REG_QUAD_TRIM: read_word = quadrature_phase_trim;
            default: read_word = 16'h0000;
        endcase
    end

    // Next state of the frame sequencer.
    always_comb begin
        next_state = state;
        unique case (state)
            TCR_IDLE: begin
                if (!sync.select_n) begin
                    next_state = TCR_SHIFT;
                end
            end
            TCR_SHIFT: begin
                if (read_armed) begin
                    next_state = TCR_READ;
                end else if (sync.select_n) begin
                    next_state = TCR_IDLE;
                end
            end
            TCR_READ: begin
                if (count == tcr_pkg::READ_CLOCKS) begin
                    next_state = TCR_IDLE;
                end
            end
            default: next_state = TCR_IDLE;
        endcase
    end

    // Sequencer state and bit counter; data sampled on link clock rising edges.
    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            state <= TCR_IDLE;
            count <= 6'h00;
            shift <= 24'h00_0000;
        end else begin
            state <= next_state;
            if (state == TCR_IDLE || (state == TCR_SHIFT && read_armed)) begin
                count <= 6'h00;
            end else if (sync.rise && count != 6'h3F) begin
                count <= count + 6'h01;
            end
            if (state == TCR_SHIFT && sync.rise && !sync.select_n) begin
                shift <= {shift[22:0], sync.data_in};
            end
        end
    end

    // Readback shifter: the selected word is presented msb first on falling edges.
    // The link clock idles low, so the first fall of the read phase follows the
    // first rise; the word is loaded on that fall, while the count stands at one.
    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            read_sel <= 5'h00;
            read_shift <= 16'h0000;
            o_serial_out <= 1'b0;
        end else begin
            if (read_armed) begin
                read_sel <= frame_data[15:11];
            end
            if (state == TCR_SHIFT && next_state == TCR_READ) begin
                read_shift <= 16'h0000;
            end else if (state == TCR_READ && count == 6'h01 && sync.fall) begin
                read_shift <= {read_word[14:0], 1'b0};
                o_serial_out <= read_word[15];
            end else if (state == TCR_READ && sync.fall) begin
                read_shift <= {read_shift[14:0], 1'b0};
                o_serial_out <= read_shift[15];
            end else if (state != TCR_READ) begin
                o_serial_out <= 1'b0;
            end
        end
    end

    // Register loads; each register is written whole, reserved bits included.
    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            stage_enables <= tcr_pkg::RST_STAGE_ENABLES;
            gain_step_control <= tcr_pkg::RST_GAIN_STEP;
            amp_bias_settings <= tcr_pkg::RST_AMP_BIAS;
            mixer_sideband_i_offset <= tcr_pkg::RST_MIX_SIDEBAND_I;
            mixer_q_offset <= tcr_pkg::RST_MIX_Q_OFFSET;
            inphase_phase_trim <= tcr_pkg::RST_INPHASE_TRIM;
            quadrature_phase_trim <= tcr_pkg::RST_QUAD_TRIM;
            read_select_reg <= 16'h0000;
        end else begin
            if (load_stage) begin
                stage_enables <= frame_data;
            end
            if (load_gain) begin
                gain_step_control <= frame_data;
            end
            if (load_bias) begin
                amp_bias_settings <= frame_data;
            end
            if (load_sideband) begin
                mixer_sideband_i_offset <= frame_data;
            end
            if (load_q_offset) begin
                mixer_q_offset <= frame_data;
            end
            if (load_read_select) begin
                read_select_reg <= frame_data;
            end
            if (load_itrim) begin
                inphase_phase_trim <= frame_data;
            end
            if (load_qtrim) begin
                quadrature_phase_trim <= frame_data;
            end
        end
    end

    // Field decode of the held registers; the output flops below register these and the whole stage_enables word.
    wire square_field = stage_enables[tcr_pkg::BIT_SQUARE_DET];
    wire envelope_field = ~stage_enables[tcr_pkg::BIT_ENVELOPE_OFF];
    wire vga_field = stage_enables[tcr_pkg::BIT_VGA_ON];
    wire mixer_field = stage_enables[tcr_pkg::BIT_IMAGE_MIXER];
    wire quad_lines_field = stage_enables[tcr_pkg::BIT_QUAD_LINES];
    wire stepped_field = stage_enables[tcr_pkg::BIT_STEPPED_AMP];
    wire lowpass_field = stage_enables[tcr_pkg::BIT_LOWPASS];
    wire [5:0] gain_field = gain_step_control[tcr_pkg::GAIN_HI:tcr_pkg::GAIN_LO];
    wire [1:0] current_field = amp_bias_settings[8:7];
    wire [4:0] level_field = amp_bias_settings[6:2];
    wire [1:0] atten_field = amp_bias_settings[1:0];
    wire sideband_field = mixer_sideband_i_offset[tcr_pkg::SIDEBAND_BIT];
    wire ipol_field = mixer_sideband_i_offset[tcr_pkg::POLARITY_BIT];
    wire [7:0] imag_field = mixer_sideband_i_offset[7:0];
    wire qpol_field = mixer_q_offset[tcr_pkg::POLARITY_BIT];
    wire [7:0] qmag_field = mixer_q_offset[7:0];
    wire [8:0] itrim_field = inphase_phase_trim[8:0];
    wire [8:0] qtrim_field = quadrature_phase_trim[8:0];

    // Registered analog controls decoded from the held registers.
    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            o_stage_enables <= tcr_pkg::RST_STAGE_ENABLES;
            o_square_detector_on <= tcr_pkg::RST_STAGE_ENABLES[tcr_pkg::BIT_SQUARE_DET];
            o_envelope_detector_on <= ~tcr_pkg::RST_STAGE_ENABLES[tcr_pkg::BIT_ENVELOPE_OFF];
            o_vga_on <= tcr_pkg::RST_STAGE_ENABLES[tcr_pkg::BIT_VGA_ON];
            o_image_mixer_on <= tcr_pkg::RST_STAGE_ENABLES[tcr_pkg::BIT_IMAGE_MIXER];
            o_mixer_quad_lines_on <= tcr_pkg::RST_STAGE_ENABLES[tcr_pkg::BIT_QUAD_LINES];
            o_stepped_amp_on <= tcr_pkg::RST_STAGE_ENABLES[tcr_pkg::BIT_STEPPED_AMP];
            o_lowpass_stage_on <= tcr_pkg::RST_STAGE_ENABLES[tcr_pkg::BIT_LOWPASS];
            o_gain_step_code <= 6'h00;
            o_amplifier_current <= 2'h3;
            o_envelope_level <= 5'h1C;
            o_attenuation_bias <= 2'h2;
            o_sideband_select <= 1'b1;
            o_inphase_offset_pol <= 1'b0;
            o_inphase_offset_mag <= 8'h00;
            o_quad_offset_pol <= 1'b0;
            o_quad_offset_mag <= 8'h00;
            o_inphase_phase_trim_val <= 9'h000;
            o_quad_phase_trim_val <= 9'h000;
        end else begin
            o_stage_enables <= stage_enables;
            o_square_detector_on <= square_field;
            o_envelope_detector_on <= envelope_field;
            o_vga_on <= vga_field;
            o_image_mixer_on <= mixer_field;
            o_mixer_quad_lines_on <= quad_lines_field;
            o_stepped_amp_on <= stepped_field;
            o_lowpass_stage_on <= lowpass_field;
            o_gain_step_code <= gain_field;
            o_amplifier_current <= current_field;
            o_envelope_level <= level_field;
            o_attenuation_bias <= atten_field;
            o_sideband_select <= sideband_field;
            o_inphase_offset_pol <= ipol_field;
            o_inphase_offset_mag <= imag_field;
            o_quad_offset_pol <= qpol_field;
            o_quad_offset_mag <= qmag_field;
            o_inphase_phase_trim_val <= itrim_field;
            o_quad_phase_trim_val <= qtrim_field;
        end
    end
endmodule // tcr_regs

// file: hdl/tcr_sync_if.sv
// Interface carrying synchronised link signals and their edge events.
`timescale 1ns/1ps
interface tcr_sync_if;
    logic select_n;
    logic data_in;
    logic rise;
    logic fall;
    modport src (output select_n, output data_in, output rise, output fall);
    modport dst (input select_n, input data_in, input rise, input fall);
endinterface
